// >>> core/rps_consts.vh
// Constants of the reset pin sequencer: counts, widths and reset values.
// Assumes one 20 MHz clock; included by bare name from core files.
`ifndef RPS_CONSTS_VH
`define RPS_CONSTS_VH
`define RPS_CLK_HZ        20000000
`define RPS_DRIVE_CYC     12'd512
`define RPS_FLOAT_CYC     12'd10
`define RPS_FIRST_BUS_CYC 12'd10
`define RPS_MSTR_MIN_CYC  12'd4
`define RPS_TSC_CYC       12'd10
`define RPS_CNT_W         12
`define RPS_TSC_MS        20
`define RPS_TSC_WORST_CYC (`RPS_TSC_MS * (`RPS_CLK_HZ / 1000))
`define RPS_WRITE_HOLD    8'h10
`define RPS_PORT_W        8
`define RPS_PORT_RST      8'h00
`define RPS_CAUSE_W       4
`define RPS_CAUSE_EXT     0
`define RPS_CAUSE_INT     1
`define RPS_CAUSE_POR     2
`define RPS_CAUSE_TSC     3
`endif

// >>> core/rps_count.v
// Loadable down counter with a done flag for the sequencer phases.
// Assumes load and enable come from the same clock domain.
`timescale 1ns/1ps
`include "rps_consts.vh"
`default_nettype none
module rps_count (
  input  wire                  clk,   // System clock
  input  wire                  rst,   // Async reset
  input  wire                  load,  // Load start value
  input  wire [`RPS_CNT_W-1:0] value, // Start value
  input  wire                  en,    // Count enable
  output wire                  done   // Count reached zero
);
  reg [`RPS_CNT_W-1:0] cnt;
  assign done = (cnt == {`RPS_CNT_W{1'b0}});
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= {`RPS_CNT_W{1'b0}};
    end else if (load) begin
      cnt <= value;
    end else if (en && !done) begin
      cnt <= cnt - 1'b1;
    end
  end
endmodule // rps_count
`default_nettype wire

// >>> core/rps_sync.v
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes asynchronous active-high reset, sampled value defaults low.
`timescale 1ns/1ps
`default_nettype none
module rps_sync (
  input  wire clk,     // System clock
  input  wire rst,     // Async reset
  input  wire d,       // Asynchronous level
  output reg  q        // Synchronised level
);
  reg meta;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // rps_sync
`default_nettype wire

// >>> core/rps_top.v
// Reset pin sequencer: stretches and re-tests the open-drain reset pin,
// holds pin states during reset and applies the three-state control.
// Assumes SYS_CLK is the bus clock; pins arrive asynchronously.
// Contract
// [R01] Ports default to inputs, functions disabled
// [R02] Integration pins inactive while reset asserted
// [R03] Mode select before reset exception processing
// [R04] Outputs run, inputs high impedance afterwards
// [R05] General-purpose port pins become hi-Z inputs
// [R06] Outside holds reset pin for minimum time
// [R07] External reset postponed until write completes; code stops waiting once wait_cnt counts down from 16 to 0
// [R08] Drive pin 512 cycles after external release
// [R09] Internal reset drives at least 512 cycles
// [R10] Float 10 cycles, sample; high starts exception
// [R11] Low sample repeats drive, float, sample
// [R12] Power-on holds until lock plus 512
// [R13] Modules reset after four master-reset cycles
// [R14] Three-state held 10 cycles then hi-Z
// [R15] External clock: hi-Z after 10 pulses
// [R16] Synthesizer clock: up to 20 ms
// [R17] After three-state, stay off until power cycle
// [R18] First bus cycle 10 cycles after release
// [R19] Record causes at release, several allowed
// [R20] Reset pin synchronised by two flip-flops
// [R21] Reset pin only pulled low or released
`timescale 1ns/1ps
`include "rps_consts.vh"
`default_nettype none
module rps_top (
  input  wire                    SYS_CLK,            // Bus clock, 20 MHz
  input  wire                    RESET,              // Async reset, high
  input  wire                    RESET_PIN_IN,       // Reset pin level
  output reg                     RESET_PIN_OUT,      // Reset pin out, always 0
  output reg                     RESET_PIN_OE,       // High pulls pin low
  input  wire                    INTERNAL_RESET_REQ, // Internal reset request
  input  wire                    POWER_ON,           // Power-on reset active
  input  wire                    SYNTH_LOCK,         // Synthesizer locked
  input  wire                    WRITE_BUSY,         // Bus write in progress
  input  wire                    THREE_STATE_CONTROL,// Three-state request
  input  wire                    CLOCK_SOURCE_SELECT,// Low selects external clock
  input  wire                    EXTERNAL_CLOCK_INPUT,// External clock pin
  output reg                     MASTER_RESET_INTERNAL, // Reset to core
  output reg                     MODULE_RESET,       // Reset to other modules
  output reg                     MODE_SAMPLE,        // Mode select strobe
  output reg                     EXCEPTION_START,    // Start reset exception
  output reg                     FIRST_BUS_GO,       // First bus cycle allowed
  output reg  [`RPS_CAUSE_W-1:0] RESET_CAUSE,        // Recorded reset causes
  output reg                     CAUSE_UPDATE,       // Cause record updated
  output reg  [`RPS_PORT_W-1:0]  PORT_DIR,           // Port direction, 1 out
  output reg  [`RPS_PORT_W-1:0]  PIN_FUNC_EN,        // Peripheral function on
  output reg                     SIM_PINS_INACTIVE,  // Integration pins idle
  output reg                     ALL_OUTPUTS_OFF     // All drivers hi-Z
);
  parameter [31:0] TSC_WORST_CYC = `RPS_TSC_WORST_CYC;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire pin_s;
  wire tsc_s;
  wire xclk_s;
  wire src_s;
  rps_sync u_sync_pin (.clk(SYS_CLK), .rst(RESET), .d(RESET_PIN_IN),
                       .q(pin_s)); // [R20]
  rps_sync u_sync_tsc (.clk(SYS_CLK), .rst(RESET), .d(THREE_STATE_CONTROL),
                       .q(tsc_s));
  rps_sync u_sync_xck (.clk(SYS_CLK), .rst(RESET), .d(EXTERNAL_CLOCK_INPUT),
                       .q(xclk_s));
  rps_sync u_sync_src (.clk(SYS_CLK), .rst(RESET), .d(CLOCK_SOURCE_SELECT),
                       .q(src_s));
  wire pin_low = ~pin_s;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_WAIT  = 7'h02;
  localparam [6:0] S_HOLD  = 7'h04;
  localparam [6:0] S_DRIVE = 7'h08;
  localparam [6:0] S_FLOAT = 7'h10;
  localparam [6:0] S_MODE  = 7'h20;
  localparam [6:0] S_BUS   = 7'h40;

  reg [6:0] state;
  reg [6:0] next_state;
  reg       ext_latched;
  reg       int_src;
  reg [`RPS_CAUSE_W-1:0] cause_acc;
  reg [7:0] wait_cnt;
  reg       por_seen;

  // Phase counter shared by drive, float and bus-start phases
  reg                   cnt_load;
  reg [`RPS_CNT_W-1:0]  cnt_value;
  wire                  cnt_done;
  rps_count u_phase (.clk(SYS_CLK), .rst(RESET), .load(cnt_load),
                     .value(cnt_value), .en(1'b1), .done(cnt_done));

  function is_driving;
    input [6:0] st;
    begin
      is_driving = (st == S_DRIVE);
    end
  endfunction

  // Pin must read high once before a low counts as an outside request
  reg pin_armed;
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      pin_armed <= 1'b0;
    end else if (pin_s) begin
      pin_armed <= 1'b1;
    end
  end

  wire int_req = INTERNAL_RESET_REQ | POWER_ON;
  wire ext_req = pin_low & pin_armed & ~is_driving(state) & (state != S_FLOAT);

  always @* begin
    next_state = state;
    cnt_load   = 1'b0;
    cnt_value  = `RPS_DRIVE_CYC;
    case (state)
      S_IDLE, S_BUS: begin
        if (int_req) begin
          next_state = S_DRIVE;
          cnt_load   = 1'b1; // [R09]
        end else if (ext_req) begin
          next_state = S_WAIT;
        end else if (state == S_BUS && cnt_done) begin
          next_state = S_IDLE;
        end
      end
      S_WAIT: begin
        if (wait_cnt == 8'h00 || !WRITE_BUSY) begin // [R07]
          next_state = S_HOLD;
        end
      end
      S_HOLD: begin
        // Outside still holds the pin; wait for its release
        if (!ext_latched) begin
          next_state = S_DRIVE;
          cnt_load   = 1'b1; // [R08]
        end
      end
      S_DRIVE: begin
        // Count stays loaded until lock and power good
        if (POWER_ON || (por_seen && !SYNTH_LOCK)) begin
          cnt_load   = 1'b1; // [R12]
        end else if (cnt_done && !int_req) begin
          next_state = S_FLOAT;
          cnt_load   = 1'b1;
          cnt_value  = `RPS_FLOAT_CYC; // [R10]
        end
      end
      S_FLOAT: begin
        if (cnt_done) begin
          cnt_load = 1'b1;
          if (pin_s) begin
            next_state = S_MODE; // [R10]
          end else begin
            next_state = S_DRIVE; // [R11]
          end
        end
      end
      S_MODE: begin
        next_state = S_BUS; // [R03]
        cnt_load   = 1'b1;
        cnt_value  = `RPS_FIRST_BUS_CYC; // [R18]
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers and cause record
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state       <= S_IDLE;
      ext_latched <= 1'b0;
      int_src     <= 1'b0;
      cause_acc   <= {`RPS_CAUSE_W{1'b0}};
      wait_cnt    <= `RPS_WRITE_HOLD;
      por_seen    <= 1'b0;
    end else begin
      state <= next_state;
      if (state == S_WAIT) begin
        wait_cnt <= wait_cnt - 8'h01;
      end else begin
        wait_cnt <= `RPS_WRITE_HOLD;
      end
      ext_latched <= (next_state == S_WAIT) | ((state == S_WAIT || state == S_HOLD) & pin_low);
      // Clear first so a cause arriving at release is kept
      if (state == S_MODE) begin
        cause_acc <= {`RPS_CAUSE_W{1'b0}};
        int_src   <= 1'b0;
        por_seen  <= 1'b0;
      end
      if (next_state == S_WAIT) begin
        cause_acc[`RPS_CAUSE_EXT] <= 1'b1;
      end
      if (INTERNAL_RESET_REQ) begin
        cause_acc[`RPS_CAUSE_INT] <= 1'b1; // [R19]
        int_src <= 1'b1;
      end
      if (POWER_ON) begin
        cause_acc[`RPS_CAUSE_POR] <= 1'b1;
        por_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Master reset and module reset after four held cycles
  // ----------------------------------------------------------------
  reg [`RPS_CNT_W-1:0] mstr_cnt;
  wire in_reset = (state != S_IDLE) && (state != S_BUS);
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      mstr_cnt <= {`RPS_CNT_W{1'b0}};
    end else if (!in_reset) begin
      mstr_cnt <= {`RPS_CNT_W{1'b0}};
    end else if (mstr_cnt < `RPS_MSTR_MIN_CYC) begin
      mstr_cnt <= mstr_cnt + 12'd1; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Three-state control
  // ----------------------------------------------------------------
  reg [`RPS_CNT_W-1:0] tsc_cnt;
  reg [31:0]           tsc_wd;
  reg                  xclk_d;
  reg                  tsc_lock;
  wire xclk_rise = xclk_s & ~xclk_d;
  wire tsc_tick  = src_s ? 1'b1 : xclk_rise; // [R15]
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      tsc_cnt  <= {`RPS_CNT_W{1'b0}};
      tsc_wd   <= 32'h00000000;
      xclk_d   <= 1'b0;
      tsc_lock <= 1'b0;
    end else begin
      xclk_d <= xclk_s;
      if (!tsc_s) begin
        tsc_cnt <= {`RPS_CNT_W{1'b0}};
        tsc_wd  <= 32'h00000000;
      end else begin
        if (tsc_tick && tsc_cnt < `RPS_TSC_CYC) begin
          tsc_cnt <= tsc_cnt + 12'd1; // [R14]
        end
        if (tsc_wd < TSC_WORST_CYC) begin
          tsc_wd <= tsc_wd + 32'h00000001; // [R16]
        end
      end
      if (tsc_s && (tsc_cnt == `RPS_TSC_CYC || tsc_wd == TSC_WORST_CYC)) begin
        tsc_lock <= 1'b1; // [R17]
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      RESET_PIN_OUT         <= 1'b0;
      RESET_PIN_OE          <= 1'b1;
      MASTER_RESET_INTERNAL <= 1'b1;
      MODULE_RESET          <= 1'b0;
      MODE_SAMPLE           <= 1'b0;
      EXCEPTION_START       <= 1'b0;
      FIRST_BUS_GO          <= 1'b0;
      RESET_CAUSE           <= {`RPS_CAUSE_W{1'b0}};
      CAUSE_UPDATE          <= 1'b0;
      PORT_DIR              <= `RPS_PORT_RST;
      PIN_FUNC_EN           <= `RPS_PORT_RST;
      SIM_PINS_INACTIVE     <= 1'b1;
      ALL_OUTPUTS_OFF       <= 1'b0;
    end else begin
      RESET_PIN_OUT         <= 1'b0; // [R21]
      RESET_PIN_OE          <= is_driving(next_state) & ~tsc_lock;
      MASTER_RESET_INTERNAL <= in_reset;
      MODULE_RESET          <= in_reset && (mstr_cnt >= `RPS_MSTR_MIN_CYC); // [R13]
      MODE_SAMPLE           <= (state == S_MODE); // [R03]
      EXCEPTION_START       <= (state == S_BUS) && cnt_done && !int_req; // [R03]
      FIRST_BUS_GO          <= (state == S_BUS) && cnt_done; // [R18]
      CAUSE_UPDATE          <= (state == S_MODE); // [R19]
      if (state == S_MODE) begin
        RESET_CAUSE <= cause_acc | {tsc_lock, 1'b0, 1'b0, 1'b0};
      end
      if (in_reset) begin
        PORT_DIR    <= `RPS_PORT_RST; // [R01]
        PIN_FUNC_EN <= `RPS_PORT_RST; // [R05]
      end
      SIM_PINS_INACTIVE <= in_reset | tsc_lock; // [R02]
      ALL_OUTPUTS_OFF   <= tsc_lock; // [R04]
    end
  end
endmodule // rps_top
`default_nettype wire

// >>> sim/rps_board.sv
// Board model: external reset source and pull-up on the reset pin.
// Assumes the bench asks for resets in the bus clock domain.
`timescale 1ns/1ps
`default_nettype none
module rps_board #(parameter int MIN_HOLD = 8) (
  input  wire logic clk,       // Bus clock
  input  wire logic pull_req,  // Bench asks for a reset
  input  wire logic drv_oe,    // Device pulls the pin low
  output wire logic pin_level  // Resolved pin level
);
  logic [7:0] hold = 8'h00;
  wire        pull_en;
  always @(posedge clk) begin
    if (pull_req) begin
      hold <= 8'(MIN_HOLD);
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end
  end
  // Pull stretched to the minimum width
  assign pull_en   = pull_req || (hold != 8'h00);
  // Pull-up wins unless someone pulls low
  assign pin_level = !(drv_oe || pull_en);
endmodule // rps_board
`default_nettype wire

// >>> sim/rps_top_assertions.sv
// Checker on the reset pin sequencer top ports, bound to rps_top.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module rps_top_checker #(parameter [31:0] TSC_WORST_CYC = 32'd400000) (
  input wire logic       SYS_CLK, RESET, THREE_STATE_CONTROL,  // Clock, reset, request
  input wire logic       RESET_PIN_OUT, RESET_PIN_OE,           // Pin driver
  input wire logic       MASTER_RESET_INTERNAL, MODULE_RESET,   // Internal resets
  input wire logic       MODE_SAMPLE, EXCEPTION_START,          // Release strobes
  input wire logic       FIRST_BUS_GO, CAUSE_UPDATE,            // Release strobes
  input wire logic       ALL_OUTPUTS_OFF, SIM_PINS_INACTIVE,    // Pin states
  input wire logic [3:0] RESET_CAUSE,                           // Cause record
  input wire logic [7:0] PORT_DIR, PIN_FUNC_EN                  // Port setup
);
  logic [15:0] drive_cnt, mr_cnt, tsc_cnt;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // Run lengths of pin drive, master reset and three-state request
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      drive_cnt <= 16'h0000;
      mr_cnt    <= 16'h0000;
      tsc_cnt   <= 16'h0000;
    end else begin
      drive_cnt <= RESET_PIN_OE ? drive_cnt + 16'h0001 : 16'h0000;
      mr_cnt    <= MASTER_RESET_INTERNAL ? mr_cnt + 16'h0001 : 16'h0000;
      tsc_cnt   <= THREE_STATE_CONTROL ? tsc_cnt + 16'h0001 : 16'h0000;
    end
  end
  chk_pin_never_high: assert property (RESET_PIN_OUT == 1'b0)
    else $error("reset pin driven high");
  chk_reset_pins_idle: assert property (MASTER_RESET_INTERNAL |-> SIM_PINS_INACTIVE)
    else $error("integration pins active in reset");
  chk_ports_as_inputs: assert property (MASTER_RESET_INTERNAL |->
    PORT_DIR == 8'h00 && PIN_FUNC_EN == 8'h00) else $error("ports not inputs in reset");
  chk_drive_length: assert property ($fell(RESET_PIN_OE) && drive_cnt > 16'h0002 |->
    drive_cnt >= 16'h0200) else $error("pin drive shorter than 512");
  chk_float_window: assert property ($fell(RESET_PIN_OE) && drive_cnt > 16'h0002 |->
    !RESET_PIN_OE [*8]) else $error("pin float window cut short");
  chk_mode_then_exc: assert property (MODE_SAMPLE |-> ##[1:12] EXCEPTION_START)
    else $error("no exception start after mode sample");
  chk_bus_with_exc: assert property (EXCEPTION_START |-> FIRST_BUS_GO)
    else $error("first bus cycle not with exception start");
  chk_cause_recorded: assert property (CAUSE_UPDATE |=> RESET_CAUSE != 4'h0)
    else $error("empty cause record");
  chk_module_reset_delay: assert property ($rose(MODULE_RESET) |-> mr_cnt >= 16'h0004)
    else $error("module reset too early");
  chk_tsc_min_hold: assert property ($rose(ALL_OUTPUTS_OFF) |-> tsc_cnt >= 16'h000a)
    else $error("three-state took effect too early");
  chk_off_sticky: assert property (ALL_OUTPUTS_OFF |=> ALL_OUTPUTS_OFF && !RESET_PIN_OE)
    else $error("left three-state without reset");
  cov_exception: cover property (EXCEPTION_START);
  cov_retest: cover property ($fell(RESET_PIN_OE) ##[1:14] $rose(RESET_PIN_OE));
  cov_outputs_off: cover property ($rose(ALL_OUTPUTS_OFF));
  cov_module_reset: cover property ($rose(MODULE_RESET));
endmodule // rps_top_checker
bind rps_top rps_top_checker #(.TSC_WORST_CYC(TSC_WORST_CYC)) rps_top_checker_inst (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .THREE_STATE_CONTROL(THREE_STATE_CONTROL),
  .RESET_PIN_OUT(RESET_PIN_OUT), .RESET_PIN_OE(RESET_PIN_OE),
  .MASTER_RESET_INTERNAL(MASTER_RESET_INTERNAL), .MODULE_RESET(MODULE_RESET),
  .MODE_SAMPLE(MODE_SAMPLE), .EXCEPTION_START(EXCEPTION_START), .FIRST_BUS_GO(FIRST_BUS_GO),
  .CAUSE_UPDATE(CAUSE_UPDATE), .ALL_OUTPUTS_OFF(ALL_OUTPUTS_OFF),
  .SIM_PINS_INACTIVE(SIM_PINS_INACTIVE), .RESET_CAUSE(RESET_CAUSE), .PORT_DIR(PORT_DIR),
  .PIN_FUNC_EN(PIN_FUNC_EN));
`default_nettype wire

// >>> sim/rps_top_bench.sv
// Self-checking bench of the reset pin sequencer with a board model.
// Assumes a 20 MHz bus clock and a shortened three-state watchdog.
`timescale 1ns/1ps
`default_nettype none
module rps_top_bench;
  logic sys_clk = 0, reset = 1, int_req = 0, power_on = 0, synth_lock = 1, busy = 0;
  logic three_state_control = 0, clk_sel = 1, ext_clk = 0, ext_run = 0, pull_req = 0, prev;
  logic pin_level, pin_out, pin_oe, mr, mod_rst, mode_s, exc, bus_go, cause_upd;
  logic sim_idle, outs_off;
  logic [3:0] cause;
  logic [7:0] port_dir, func_en;
  integer miscompares = 0, cmp_count = 0, seed = 32'h0e608732;
  integer t_on, t_fall, rises, ms, ex, upd, k, len, bad;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) ext_clk <= ext_run & ~ext_clk;
  rps_top #(.TSC_WORST_CYC(32'd50)) rps_top_inst (.SYS_CLK(sys_clk), .RESET(reset),
    .RESET_PIN_IN(pin_level), .RESET_PIN_OUT(pin_out), .RESET_PIN_OE(pin_oe),
    .INTERNAL_RESET_REQ(int_req), .POWER_ON(power_on), .SYNTH_LOCK(synth_lock),
    .WRITE_BUSY(busy), .THREE_STATE_CONTROL(three_state_control), .CLOCK_SOURCE_SELECT(clk_sel),
    .EXTERNAL_CLOCK_INPUT(ext_clk), .MASTER_RESET_INTERNAL(mr), .MODULE_RESET(mod_rst),
    .MODE_SAMPLE(mode_s), .EXCEPTION_START(exc), .FIRST_BUS_GO(bus_go), .RESET_CAUSE(cause),
    .CAUSE_UPDATE(cause_upd), .PORT_DIR(port_dir), .PIN_FUNC_EN(func_en),
    .SIM_PINS_INACTIVE(sim_idle), .ALL_OUTPUTS_OFF(outs_off));
  rps_board #(.MIN_HOLD(8)) rps_board_inst (.clk(sys_clk), .pull_req(pull_req),
    .drv_oe(pin_oe), .pin_level(pin_level));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: value %0h, expected %0h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task do_reset;
    begin
      @(posedge sys_clk) reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) check({pin_oe, pin_out, mr, sim_idle, port_dir, func_en}, 20'hb0000);
      @(posedge sys_clk) reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  // ----------------------------------------
  // One reset sequence: 0 internal, 1 external, 2 power-on, 3 retest
  // ----------------------------------------
  task run(input integer sel, input integer len);
    integer n, low_run, exp_cause;
    begin
      t_on = -1; t_fall = -1; rises = 0; ms = -1; ex = -1; upd = 0; low_run = 0; prev = pin_oe;
      for (n = 0; n < 4000 && !(rises > 0 && low_run > 40); n = n + 1) begin
        @(posedge sys_clk);
        int_req    <= (sel == 0 && n < len) || (sel == 3 && n == 0);
        pull_req   <= (sel == 1 && n < len) || (sel == 3 && n >= 100 && n < 600);
        busy       <= sel == 1 && n < 12;
        power_on   <= sel == 2 && n < len;
        synth_lock <= !(sel == 2 && n < len);
        @(negedge sys_clk);
        if (pin_oe === 1'b1 && prev !== 1'b1) rises = rises + 1;
        if (pin_oe === 1'b1 && t_on < 0) t_on = n;
        if (pin_oe === 1'b0 && prev === 1'b1) t_fall = n;
        if (t_on >= 0 && n == t_on + 5) check({pin_out, mr, sim_idle, port_dir, func_en}, 19'h30000);
        if (mode_s === 1'b1) ms = n;
        if (exc === 1'b1) ex = n;
        if (exc === 1'b1) check(bus_go, 1'b1);
        if (cause_upd === 1'b1) upd = 1;
        low_run = (pin_oe === 1'b0) ? low_run + 1 : 0;
        prev = pin_oe;
      end
      check(ms - t_fall >= 9 && ms - t_fall <= 14, 1'b1);
      check(ex > ms && ex <= ms + 12, 1'b1);
      check(upd, 1);
      exp_cause = (sel == 1) ? 1 : (sel == 2) ? 4 : 2;
      check(cause & exp_cause[3:0], exp_cause[3:0]);
      case (sel)
        0: check(t_fall - t_on >= 512 && t_fall >= len, 1'b1);
        1: check(t_fall - len >= 512 && t_on >= 12, 1'b1);
        2: check(t_fall - len >= 512, 1'b1);
        default: check(rises, 2);
      endcase
    end
  endtask
  task tsc_run(input logic ext);
    begin
      @(posedge sys_clk) clk_sel <= ~ext;
      ext_run <= ext;
      do_reset;
      @(posedge sys_clk) three_state_control <= 1'b1;
      for (k = 0; k < 200 && outs_off !== 1'b1; k = k + 1) @(negedge sys_clk);
      check(k >= (ext ? 19 : 10) && k <= (ext ? 40 : 60), 1'b1);
      @(posedge sys_clk) three_state_control <= 1'b0;
      int_req <= 1'b1;
      bad = 0;
      repeat (600) @(negedge sys_clk) if (pin_oe !== 1'b0 || outs_off !== 1'b1) bad = 1;
      check(bad, 0);
      @(posedge sys_clk) int_req <= 1'b0;
    end
  endtask
  initial begin
    do_reset;
    for (k = 0; k < 8; k = k + 1) begin
      len = 20 + ({$random(seed)} % 700);
      run(k % 4, (k == 0) ? 1 : len);
    end
    tsc_run(1'b1);
    tsc_run(1'b0);
    do_reset;
    report_and_stop;
  end
  initial begin
    #(50 * 30000);
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule // rps_top_bench
`default_nettype wire
